/* File: sdp_pkg.sv */
// shared constants and types for the serial data packer
package sdp_pkg;
   // buffer geometry
   localparam int BUF_BYTES = 1024;           // receive buffer per port
   localparam int LEN_W = 11;                 // holds 0..1024
   localparam int HOSTS = 4;                  // connected host slots
   // timing: clock period and derived millisecond divider
   localparam int CLK_PERIOD_PS = 5000;       // 200 MHz
   localparam int MS_IN_PS = 1000000000;      // one millisecond
   localparam int MS_CYCLES = MS_IN_PS / CLK_PERIOD_PS;
   localparam int MIN_IN_MS = 60000;          // one minute in ms
   localparam int DIV_W = 18;                 // width of ms divider
   // session supervision defaults
   localparam logic [6:0] TCP_IDLE_DEFAULT_MIN = 7'h07;
   localparam logic [15:0] SER_IDLE_DEFAULT_MS = 16'h0000;
   localparam logic [15:0] KA_PERIOD_MS = 16'h2710;  // probe interval
   localparam logic [15:0] KA_WAIT_MS = 16'h07D0;    // answer window
   localparam logic [15:0] STALL_MS = 16'h03E8;      // peer stall limit
   // delimiter handling modes
   localparam logic [1:0] DMODE_NONE = 2'h0;
   localparam logic [1:0] DMODE_PLUS1 = 2'h1;
   localparam logic [1:0] DMODE_PLUS2 = 2'h2;
   localparam logic [1:0] DMODE_STRIP = 2'h3;
   // session close causes
   localparam logic [1:0] CLOSE_NONE = 2'h0;
   localparam logic [1:0] CLOSE_TCP_IDLE = 2'h1;
   localparam logic [1:0] CLOSE_SER_IDLE = 2'h2;
   localparam logic [1:0] CLOSE_KEEPALIVE = 2'h3;
   // one byte of a frame on its way out
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } sdp_byte_t;
   // packing configuration
   typedef struct packed {
      logic [LEN_W-1:0] flush_count;
      logic [7:0] delim1;
      logic [7:0] delim2;
      logic [1:0] delim_mode;
      logic [15:0] force_ms;
   } sdp_pack_cfg_t;
   // session configuration
   typedef struct packed {
      logic [6:0] tcp_idle_check_time;
      logic [15:0] serial_idle_ms;
      logic connect_on_any_char;
      logic stalled_peer_skip;
      logic [2:0] max_conn;
   } sdp_sess_cfg_t;
   // packer phases
   typedef enum logic {SDP_FILL, SDP_DRAIN} sdp_phase_t;
endpackage : sdp_pkg

/* File: sdp_fifo.sv */
// small first-word-fall-through fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdp_fifo
   import sdp_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // pointers carry one wrap bit so full and empty differ
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sdp_fifo_st_t;
   sdp_fifo_st_t s, next_s;
   logic [WIDTH-1:0] mem [DEPTH];             // storage words
   logic do_wr, do_rd;
   // full when pointers differ only in the wrap bit
   assign in_ready = !((s.wp[AW] != s.rp[AW]) &&
      (s.wp[AW-1:0] == s.rp[AW-1:0]));
   assign out_valid = (s.wp != s.rp);
   assign out_data = mem[s.rp[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   // pointer update
   always_comb
   begin
      next_s = s;
      if (do_wr)
         next_s.wp = s.wp + 1'b1;
      if (do_rd)
         next_s.rp = s.rp + 1'b1;
   end
   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
   // storage write
   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[s.wp[AW-1:0]] <= in_data;
   end
endmodule : sdp_fifo

/* File: sdp_packer.sv */
// serial byte packer with session supervision and host pacing
`timescale 1ns/1ps
module sdp_packer
   import sdp_pkg::*;
#(
   parameter int MS_DIV = MS_CYCLES,          // clock cycles per ms
   parameter int MIN_DIV = MIN_IN_MS,         // ms per minute
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // serial byte input
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   // configuration
   input wire sdp_pack_cfg_t pack_cfg,
   input wire sdp_sess_cfg_t sess_cfg,
   // frame output towards the network side
   output logic frame_valid,
   input wire logic frame_ready,
   output sdp_byte_t frame_byte,
   // session status from the network side
   input wire logic session_open,
   input wire logic tcp_activity,
   input wire logic serial_tx_activity,
   input wire logic keepalive_ack,
   input wire logic [HOSTS-1:0] host_active,
   input wire logic [HOSTS-1:0] host_ack,
   // session control outputs
   output logic session_close,
   output logic [1:0] close_reason,
   output logic keepalive_probe,
   output logic [HOSTS-1:0] host_drop,
   output logic group_wait
);
   // full state of the packer
   typedef struct packed {
      sdp_phase_t phase;
      logic [LEN_W-1:0] len;                  // bytes held in buffer
      logic [LEN_W-1:0] rd;                   // drain index
      logic [LEN_W-1:0] flen;                 // length of frame draining
      logic d1_seen;                          // last byte was delim1
      logic [1:0] tail;                       // bytes still owed after delim
      logic [DIV_W-1:0] div;                  // cycle divider
      logic [15:0] min_div;                   // ms within minute
      logic tick_ms;
      logic tick_min;
      logic [15:0] gap_ms;                    // ms since last byte
      logic [15:0] ser_ms;                    // serial idle ms
      logic [6:0] tcp_min;                    // tcp idle minutes
      logic [15:0] ka_ms;                     // keep-alive timer
      logic ka_wait;                          // probe outstanding
      logic close;
      logic [1:0] reason;
      logic probe;
      logic [HOSTS-1:0] wait_mask;            // hosts yet to accept group
      logic [15:0] stall_ms;
      logic [HOSTS-1:0] drop;
   } sdp_state_t;

   sdp_state_t s, next_s;
   logic rst_meta, rst_n;                     // reset release chain
   logic [7:0] buf_mem [BUF_BYTES];           // receive buffer
   logic byte_take;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   sdp_byte_t fifo_in, fifo_out;
   logic delims_on, two_char, is_match, flush, skip_on;
   logic [LEN_W-1:0] nlen;

   // saturating millisecond counter step
   function automatic logic [15:0] sat_inc16(input logic [15:0] v);
      sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : sat_inc16

   // reset release through two flops
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // byte acceptance and delimiter decode
   assign rx_ready = (s.phase == SDP_FILL);
   assign byte_take = rx_valid && rx_ready;
   assign delims_on = (pack_cfg.delim1 != 8'h00);
   assign two_char = (pack_cfg.delim2 != 8'h00);
   assign is_match = two_char ?
      (s.d1_seen && rx_data == pack_cfg.delim2) :
      (rx_data == pack_cfg.delim1);
   assign nlen = s.len + 11'h001;
   assign skip_on = sess_cfg.stalled_peer_skip &&
      (sess_cfg.max_conn > 3'h1);

   // buffer write, one byte per accepted input
   always_ff @(posedge mclk)
   begin
      if (byte_take)
         buf_mem[s.len[9:0]] <= rx_data;
   end

   // frame bytes leave the buffer through the fifo
   assign fifo_in.data = buf_mem[s.rd[9:0]];
   assign fifo_in.last = (s.rd == s.flen - 11'h001);
   // a group is held back until every active host took the last one or was dropped
   assign frame_valid = fifo_out_valid && (s.wait_mask == '0);
   assign fifo_pop = frame_valid && frame_ready;
   assign frame_byte = fifo_out;

   sdp_fifo #(
      .WIDTH($bits(sdp_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(mclk),
      .rst_n(rst_n),
      .in_valid(s.phase == SDP_DRAIN),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(frame_ready && (s.wait_mask == '0)),
      .out_data(fifo_out)
   );

   // next-state logic for packing, timers, session and hosts
   always_comb
   begin
      next_s = s;
      flush = 1'b0;
      next_s.tick_ms = 1'b0;
      next_s.tick_min = 1'b0;
      next_s.close = 1'b0;
      next_s.reason = CLOSE_NONE;
      next_s.probe = 1'b0;
      next_s.drop = '0;
      // millisecond and minute ticks
      if (s.div == DIV_W'(MS_DIV - 1))
      begin
         next_s.div = '0;
         next_s.tick_ms = 1'b1;
      end
      else
         next_s.div = s.div + 1'b1;
      if (s.tick_ms)
      begin
         if (s.min_div == 16'(MIN_DIV - 1))
         begin
            next_s.min_div = 16'h0000;
            next_s.tick_min = 1'b1;
         end
         else
            next_s.min_div = s.min_div + 16'h0001;
      end
      // packing
      unique case (s.phase)
         SDP_FILL:
         begin
            if (byte_take)
            begin
               next_s.len = nlen;
               next_s.gap_ms = 16'h0000;
               next_s.d1_seen = two_char &&
                  (rx_data == pack_cfg.delim1);
               if (s.tail != 2'h0)
               begin
                  // trailing bytes after a delimiter
                  next_s.tail = s.tail - 2'h1;
                  flush = (s.tail == 2'h1);
               end
               else if (!delims_on)
                  flush = 1'b1;
               else if (is_match)
               begin
                  unique case (pack_cfg.delim_mode)
                     DMODE_NONE: flush = 1'b1;
                     DMODE_PLUS1: next_s.tail = 2'h1;
                     DMODE_PLUS2: next_s.tail = 2'h2;
                     DMODE_STRIP:
                     begin
                        // drop the delimiter bytes from the frame
                        flush = 1'b1;
                        if (two_char)
                           next_s.len = (nlen > 11'h002) ?
                              nlen - 11'h002 : 11'h000;
                        else
                           next_s.len = s.len;
                     end
                  endcase
               end
               // length limit only when programmed nonzero
               if (pack_cfg.flush_count != 11'h000 &&
                   nlen == pack_cfg.flush_count)
                  flush = 1'b1;
               if (nlen == LEN_W'(BUF_BYTES))
                  flush = 1'b1;
            end
            else if (s.tick_ms && s.len != 11'h000)
            begin
               // inter-byte gap timeout
               next_s.gap_ms = sat_inc16(s.gap_ms);
               if (pack_cfg.force_ms != 16'h0000 &&
                   sat_inc16(s.gap_ms) >= pack_cfg.force_ms)
                  flush = 1'b1;
            end
            if (flush)
            begin
               next_s.tail = 2'h0;
               next_s.d1_seen = 1'b0;
               next_s.flen = next_s.len;
               next_s.rd = 11'h000;
               next_s.len = 11'h000;
               next_s.gap_ms = 16'h0000;
               // an empty frame (all stripped) sends nothing
               next_s.phase = (next_s.flen != 11'h000) ?
                  SDP_DRAIN : SDP_FILL;
            end
         end
         SDP_DRAIN:
         begin
            // copy out one byte per cycle while the fifo has room
            if (fifo_in_ready)
            begin
               next_s.rd = s.rd + 11'h001;
               if (fifo_in.last)
                  next_s.phase = SDP_FILL;
            end
         end
      endcase
      // session supervision
      if (!session_open || s.close)
      begin
         next_s.tcp_min = 7'h00;
         next_s.ser_ms = 16'h0000;
         next_s.ka_ms = 16'h0000;
         next_s.ka_wait = 1'b0;
      end
      else
      begin
         // idle tcp in minutes
         if (tcp_activity)
            next_s.tcp_min = 7'h00;
         else if (s.tick_min && s.tcp_min != 7'h7F)
            next_s.tcp_min = s.tcp_min + 7'h01;
         if (sess_cfg.tcp_idle_check_time != 7'h00 &&
             s.tcp_min >= sess_cfg.tcp_idle_check_time)
         begin
            next_s.close = 1'b1;
            next_s.reason = CLOSE_TCP_IDLE;
         end
         // idle serial in either direction
         if (byte_take || serial_tx_activity)
            next_s.ser_ms = 16'h0000;
         else if (s.tick_ms)
            next_s.ser_ms = sat_inc16(s.ser_ms);
         if (sess_cfg.serial_idle_ms != 16'h0000)
         begin
            next_s.ka_ms = 16'h0000;
            next_s.ka_wait = 1'b0;
            if (sess_cfg.connect_on_any_char &&
                s.ser_ms >= sess_cfg.serial_idle_ms)
            begin
               next_s.close = 1'b1;
               next_s.reason = CLOSE_SER_IDLE;
            end
         end
         else
         begin
            // keep-alive probing while the serial idle time is zero
            if (s.tick_ms)
               next_s.ka_ms = sat_inc16(s.ka_ms);
            if (s.ka_wait && keepalive_ack)
            begin
               next_s.ka_wait = 1'b0;
               next_s.ka_ms = 16'h0000;
            end
            else if (s.ka_wait && s.ka_ms >= KA_WAIT_MS)
            begin
               next_s.close = 1'b1;
               next_s.reason = CLOSE_KEEPALIVE;
            end
            else if (!s.ka_wait && s.ka_ms >= KA_PERIOD_MS)
            begin
               next_s.probe = 1'b1;
               next_s.ka_wait = 1'b1;
               next_s.ka_ms = 16'h0000;
            end
         end
      end
      // host pacing between frame groups
      if (fifo_pop && fifo_out.last)
      begin
         next_s.wait_mask = host_active;
         next_s.stall_ms = 16'h0000;
      end
      else if (s.wait_mask != '0)
      begin
         next_s.wait_mask = s.wait_mask & ~host_ack & host_active;
         if (skip_on && s.tick_ms)
            next_s.stall_ms = sat_inc16(s.stall_ms);
         if (skip_on && s.stall_ms >= STALL_MS)
         begin
            // give up on hosts that never answered
            next_s.drop = next_s.wait_mask;
            next_s.wait_mask = '0;
         end
      end
   end

   // state register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   // session outputs straight from state
   assign session_close = s.close;
   assign close_reason = s.reason;
   assign keepalive_probe = s.probe;
   assign host_drop = s.drop;
   assign group_wait = (s.wait_mask != '0);
endmodule : sdp_packer

/* File: sdp_packer_properties.sv */
// concurrent checks on the packer's ports
`timescale 1ns/1ps
module sdp_packer_properties
   import sdp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // serial side
   input wire logic rx_valid,
   input wire logic rx_ready,
   // configuration
   input wire sdp_pack_cfg_t pack_cfg,
   input wire sdp_sess_cfg_t sess_cfg,
   // frame side
   input wire logic frame_valid,
   input wire logic frame_ready,
   input wire sdp_byte_t frame_byte,
   // session side
   input wire logic session_close,
   input wire logic [1:0] close_reason,
   input wire logic keepalive_probe,
   input wire logic [HOSTS-1:0] host_drop,
   input wire logic group_wait
);
   // one clock domain, reset masks every check
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // a close always names its cause
   chk_close_cause:
   assert property (session_close |-> close_reason != CLOSE_NONE)
      else $error("close pulse without cause");
   // cause reads zero between closes
   chk_reason_idle:
   assert property (!session_close |-> close_reason == CLOSE_NONE)
      else $error("cause shown without close");
   // close and probe are single-cycle pulses
   chk_close_pulse:
   assert property (session_close |=> !session_close)
      else $error("close pulse too long");
   chk_probe_pulse:
   assert property (keepalive_probe |=> !keepalive_probe)
      else $error("probe pulse too long");
   // tcp idle close needs a non-zero minute count
   chk_tcp_gate:
   assert property (session_close && close_reason == CLOSE_TCP_IDLE
      |-> sess_cfg.tcp_idle_check_time != 7'h00)
      else $error("tcp idle close while disabled");
   // serial idle close needs a time and any-character connect
   chk_serial_gate:
   assert property (session_close && close_reason == CLOSE_SER_IDLE
      |-> sess_cfg.connect_on_any_char && sess_cfg.serial_idle_ms != 0)
      else $error("serial idle close while disabled");
   // keep-alive only while serial idle close is off
   chk_keepalive_gate:
   assert property (keepalive_probe || (session_close
      && close_reason == CLOSE_KEEPALIVE) |-> sess_cfg.serial_idle_ms == 0)
      else $error("keep-alive active with serial idle on");
   // peers are dropped only with skipping on and several connections
   chk_drop_gate:
   assert property (host_drop != '0 |-> sess_cfg.stalled_peer_skip
      && sess_cfg.max_conn > 3'h1)
      else $error("host dropped while skipping off");
   // waiting on hosts blocks the next group
   chk_group_hold:
   assert property (group_wait |-> !frame_valid)
      else $error("frame offered while waiting on hosts");
   // without delimiter, or with count one outside strip mode, each byte drains at once
   chk_byte_flush:
   assert property (rx_valid && rx_ready && (pack_cfg.delim1 == 8'h00
      || pack_cfg.flush_count == 11'h001
      && pack_cfg.delim_mode != DMODE_STRIP) |=> !rx_ready)
      else $error("lone byte not flushed");
   // an offered frame byte stays put until taken
   chk_byte_stands:
   assert property (frame_valid && !frame_ready
      |=> frame_valid && $stable(frame_byte))
      else $error("frame byte changed before taken");
endmodule : sdp_packer_properties

/* File: sdp_net_sink.sv */
// network-side frame sink with pacing and host acknowledge
`timescale 1ns/1ps
module sdp_net_sink
   import sdp_pkg::*;
(
   // clock
   input wire logic mclk,
   // bench controls: slow pacing, acks allowed, hosts present
   input wire logic stall,
   input wire logic ack_en,
   input wire logic [HOSTS-1:0] host_active,
   // frame stream from the packer
   input wire logic frame_valid,
   output logic frame_ready,
   input wire sdp_byte_t frame_byte,
   // acknowledge pulses back to the packer
   output logic [HOSTS-1:0] host_ack
);
   sdp_byte_t got [$]; // bytes taken, in order
   logic [1:0] pace = 2'h0; // slow-mode phase
   logic [2:0] dly = 3'h0; // cycles until the group is acked
   initial
   begin
      frame_ready = 1'b0;
      host_ack = '0;
   end
   // take bytes, pace ready, ack a group a few cycles after its end
   always @(posedge mclk)
   begin
      if (frame_valid && frame_ready)
         got.push_back(frame_byte);
      if (frame_valid && frame_ready && frame_byte.last)
         dly <= 3'h4;
      else if (dly > 3'h1 || (dly == 3'h1 && ack_en))
         dly <= dly - 3'h1;
      pace <= pace + 2'h1;
      // stalled: one byte in four
      frame_ready <= !stall || pace == 2'h0;
      host_ack <= (dly == 3'h1 && ack_en) ? host_active : '0;
   end
endmodule : sdp_net_sink

/* File: serial_data_packer_tcp_client_tb.sv */
// self-checking bench for the serial data packer
`timescale 1ns/1ps
module serial_data_packer_tcp_client_tb
   import sdp_pkg::*;
;
   // one table row: packing setup, bytes in, bytes out
   typedef struct packed {
      logic [10:0] fc;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [1:0] md;
      logic [31:0] din;
      logic [2:0] nin;
      logic [35:0] dout;
      logic [2:0] nout;
   } sdp_row_t;
   sdp_row_t rows [8] = '{
      '{11'h000, 8'h00, 8'h00, DMODE_NONE, 32'h4142_0000, 3'h2,
        {9'h141, 9'h142, 18'h0}, 3'h2},
      '{11'h000, 8'h0A, 8'h00, DMODE_NONE, 32'h4142_0A00, 3'h3,
        {9'h041, 9'h042, 9'h10A, 9'h0}, 3'h3},
      '{11'h000, 8'h0D, 8'h0A, DMODE_NONE, 32'h0D41_0D0A, 3'h4,
        {9'h00D, 9'h041, 9'h00D, 9'h10A}, 3'h4},
      '{11'h000, 8'h0A, 8'h00, DMODE_PLUS1, 32'h410A_4200, 3'h3,
        {9'h041, 9'h00A, 9'h142, 9'h0}, 3'h3},
      '{11'h000, 8'h0A, 8'h00, DMODE_PLUS2, 32'h0A41_4200, 3'h3,
        {9'h00A, 9'h041, 9'h142, 9'h0}, 3'h3},
      '{11'h000, 8'h0A, 8'h00, DMODE_STRIP, 32'h0A41_420A, 3'h4,
        {9'h041, 9'h142, 18'h0}, 3'h2},
      '{11'h003, 8'h0A, 8'h00, DMODE_NONE, 32'h4142_4300, 3'h3,
        {9'h041, 9'h042, 9'h143, 9'h0}, 3'h3},
      '{11'h000, 8'h00, 8'h0A, DMODE_NONE, 32'h410A_0000, 3'h2,
        {9'h141, 9'h10A, 18'h0}, 3'h2}};
   // design ports and bench controls
   logic mclk, resetn, rx_valid, rx_ready;
   logic [7:0] rx_data;
   sdp_pack_cfg_t pack_cfg;
   sdp_sess_cfg_t sess_cfg;
   logic frame_valid, frame_ready;
   sdp_byte_t frame_byte;
   logic session_open, tcp_activity, serial_tx_activity, keepalive_ack;
   logic [HOSTS-1:0] host_active, host_ack, host_drop;
   logic session_close, keepalive_probe, group_wait, stall, ack_en;
   logic [1:0] close_reason;
   // tallies and captured events
   int err_count = 0;
   int checked = 0;
   int n_close = 0;
   int n_probe = 0;
   logic [1:0] reason = 2'h0;
   logic [HOSTS-1:0] drop = '0;
   // design with short ms and minute dividers
   sdp_packer #(.MS_DIV(4), .MIN_DIV(3), .FIFO_DEPTH(8)) u_dut (.mclk,
      .resetn, .rx_valid, .rx_ready, .rx_data, .pack_cfg, .sess_cfg,
      .frame_valid, .frame_ready, .frame_byte, .session_open,
      .tcp_activity, .serial_tx_activity, .keepalive_ack, .host_active,
      .host_ack, .session_close, .close_reason, .keepalive_probe,
      .host_drop, .group_wait);
   // network side
   sdp_net_sink u_sink (.mclk, .stall, .ack_en, .host_active,
      .frame_valid, .frame_ready, .frame_byte, .host_ack);
   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // capture session events seen at the ports
   always @(posedge mclk)
   begin
      if (session_close === 1'b1)
         n_close <= n_close + 1;
      if (session_close === 1'b1)
         reason <= close_reason;
      if (keepalive_probe === 1'b1)
         n_probe <= n_probe + 1;
      if (host_drop !== 4'h0)
         drop <= host_drop;
   end
   // compare and tally
   task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk
   // offer one byte and hold it until the edge that takes it
   task send(input logic [7:0] b);
      int k;
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data = b;
      k = 0;
      do
      begin
         @(posedge mclk);
         k++;
      end
      while (rx_ready !== 1'b1 && k < 5000);
   endtask : send
   // release the lane; data turns over so it never looks held
   task idle;
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask : idle
   // bounded wait for bytes at the sink
   task wait_bytes(input int n, input int lim);
      for (int k = 0; k < lim && u_sink.got.size() < n; k++)
         @(negedge mclk);
   endtask : wait_bytes
   // bounded wait for a close, check its cause, end the session
   task close_wait(input int lim, input logic [1:0] why);
      int base;
      base = n_close;
      for (int k = 0; k < lim && n_close == base; k++)
         @(negedge mclk);
      chk("close reason", {7'h00, why}, {7'h00, reason});
      session_open = 1'b0;
      repeat (4) @(negedge mclk);
   endtask : close_wait
   // verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   // hang guard
   initial
   begin
      repeat (70000) @(posedge mclk);
      err_count++;
      conclude();
   end
   // main sequence
   initial
   begin
      int c0;
      int k;
      sdp_byte_t b;
      resetn = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      pack_cfg = '0;
      sess_cfg = '0;
      session_open = 1'b0;
      tcp_activity = 1'b0;
      serial_tx_activity = 1'b0;
      keepalive_ack = 1'b0;
      host_active = '0;
      stall = 1'b0;
      ack_en = 1'b1;
      repeat (5) @(negedge mclk);
      chk("rx_ready in reset", 9'h001, {8'h00, rx_ready});
      chk("frame_valid in reset", 9'h000, {8'h00, frame_valid});
      @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      // table of packing cases
      foreach (rows[i])
      begin
         pack_cfg = '{rows[i].fc, rows[i].d1, rows[i].d2, rows[i].md, 16'h0};
         for (k = 0; k < rows[i].nin; k++)
            send(rows[i].din[31-8*k -: 8]);
         idle();
         wait_bytes(rows[i].nout, 100);
         for (k = 0; k < rows[i].nout; k++)
         begin
            b = u_sink.got.pop_front();
            chk("row byte", rows[i].dout[35-9*k -: 9], b);
         end
         repeat (10) @(negedge mclk);
      end
      // lone byte leaves only after the quiet time
      pack_cfg = '{11'h000, 8'h0A, 8'h00, DMODE_NONE, 16'h0002};
      send(8'h41);
      idle();
      chk("force early", 9'h000, 9'(u_sink.got.size()));
      wait_bytes(1, 60);
      b = u_sink.got.pop_front();
      chk("force byte", 9'h141, b);
      // full buffer with delim1 still 0A but no 0A in the data, sink stalling
      pack_cfg.force_ms = 16'h0000;
      stall = 1'b1;
      for (k = 0; k < BUF_BYTES; k++)
         send(8'h41);
      idle();
      wait_bytes(BUF_BYTES, 6000);
      for (k = 0; k < BUF_BYTES; k++)
      begin
         b = u_sink.got.pop_front();
         chk("full byte", {k == BUF_BYTES - 1, 8'h41}, b);
      end
      stall = 1'b0;
      // two silent hosts hold the next group until acked
      ack_en = 1'b0;
      host_active = 4'h3;
      sess_cfg = '{7'h00, 16'h0000, 1'b0, 1'b0, 3'h2};
      pack_cfg.delim1 = 8'h00;
      send(8'h55);
      idle();
      repeat (10) @(negedge mclk);
      chk("group wait", 9'h001, {8'h00, group_wait});
      send(8'h56);
      idle();
      repeat (20) @(negedge mclk);
      chk("held group", 9'h001, 9'(u_sink.got.size()));
      ack_en = 1'b1;
      wait_bytes(2, 40);
      b = u_sink.got.pop_front();
      chk("group one", 9'h155, b);
      b = u_sink.got.pop_front();
      chk("group two", 9'h156, b);
      // skipping on: silent hosts kept with one connection, dropped with two
      repeat (10) @(negedge mclk);
      ack_en = 1'b0;
      sess_cfg.stalled_peer_skip = 1'b1;
      sess_cfg.max_conn = 3'h1;
      send(8'h57);
      idle();
      repeat (4100) @(negedge mclk);
      chk("one-link drop", 9'h000, {5'h00, drop});
      sess_cfg.max_conn = 3'h2;
      for (k = 0; k < 4200 && drop == 4'h0; k++)
         @(negedge mclk);
      chk("dropped hosts", 9'h003, {5'h00, drop});
      b = u_sink.got.pop_front();
      chk("group three", 9'h157, b);
      host_active = 4'h0;
      ack_en = 1'b1;
      // tcp activity keeps the session, two quiet minutes close it
      sess_cfg = '{7'h02, 16'h0000, 1'b0, 1'b0, 3'h1};
      session_open = 1'b1;
      c0 = n_close;
      repeat (8)
      begin
         repeat (5) @(negedge mclk);
         tcp_activity = 1'b1;
         @(negedge mclk);
         tcp_activity = 1'b0;
      end
      chk("tcp early close", 9'(c0), 9'(n_close));
      close_wait(60, CLOSE_TCP_IDLE);
      // serial idle close with any-character connect
      sess_cfg = '{7'h00, 16'h0003, 1'b1, 1'b0, 3'h1};
      session_open = 1'b1;
      close_wait(40, CLOSE_SER_IDLE);
      // other connect condition: serial idle has no effect
      sess_cfg.connect_on_any_char = 1'b0;
      session_open = 1'b1;
      c0 = n_close;
      repeat (60) @(negedge mclk);
      chk("serial close gated", 9'(c0), 9'(n_close));
      session_open = 1'b0;
      @(negedge mclk);
      // keep-alive probe, unanswered, forces the close
      sess_cfg.serial_idle_ms = 16'h0000;
      session_open = 1'b1;
      c0 = n_probe;
      for (k = 0; k < 40100 && n_probe == c0; k++)
         @(negedge mclk);
      chk("probe sent", 9'(c0 + 1), 9'(n_probe));
      close_wait(8100, CLOSE_KEEPALIVE);
      conclude();
   end
endmodule : serial_data_packer_tcp_client_tb
// checker on the design's ports
bind sdp_packer sdp_packer_properties u_chk (.mclk, .resetn, .rx_valid,
   .rx_ready, .pack_cfg, .sess_cfg, .frame_valid, .frame_ready,
   .frame_byte, .session_close, .close_reason, .keepalive_probe,
   .host_drop, .group_wait);
